/* hdl/ctu_top.sv */
// Control registers, edge status logic and Avalon-MM slave of the measurement unit.
//
// Contract
// (RQ1) High bit seven enables unit; reset zero.
// (RQ2) Idle-stop bit suspends unit during Idle; the code blocks only the edges, and the current source is not stopped.
// (RQ3) Delay-generation bit selects delay mode.
// (RQ4) Edge gate zero blocks all edges.
// (RQ5) Order bit: second edge needs first.
// (RQ6) Ground bit ties current source low.
// (RQ7) Trigger bit enables converter trigger output.
// (RQ8) High bit six ignores writes, reads zero.
// (RQ9) Second polarity: one high, zero low.
// (RQ10) First polarity: one high, zero low.
// (RQ11) Second source select: pins and captures.
// (RQ12) First source uses same encoding.
// (RQ13) Second flag shows event; software writable.
// (RQ14) First flag shows event; software writable.
// (RQ15) Edge inputs level-sensitive from four sources.
// (RQ16) Unit can start converter conversion.
// (RQ17) Hardware sets flag on detected event.
// (RQ18) Matching reconfiguration sets flag at once.
// (RQ19) Current on when exactly one flag set.
// (RQ20) Interrupt flag on current on-to-off.
// (RQ21) Synchronise external edge pins first.
// (RQ22) One-cycle trigger when both flags set.
//
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ns
`include "ctu_defs.svh"
module ctu_top (
   input  wire logic        i_clock,
   input  wire logic        i_reset,
   input  wire logic [3:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest,
   output logic             o_avs_response_err,
   input  wire logic        i_idle_mode,
   input  wire logic        i_ext_edge_pin_one,
   input  wire logic        i_ext_edge_pin_two,
   input  wire logic        i_capture_unit_one,
   input  wire logic        i_capture_unit_two,
   output logic             o_unit_enable,
   output logic             o_delay_gen_enable,
   output logic             o_current_enable,
   output logic             o_source_ground,
   output logic             o_conv_trigger,
   output logic             o_unit_int_flag
);
   typedef struct packed {
      ctu_pkg::ctu_bus_state_t bus;
      logic [31:0]             rdata;
      logic                    err;
      logic [7:0]              high;
      logic [7:0]              low;
      logic [1:0]              pin_meta;
      logic [1:0]              pin_sync;
      logic                    current;
      logic                    trig;
      logic                    int_flag;
   } ctu_state_t;

   ctu_state_t state;
   ctu_state_t next_state;

   ctu_edge_if chan_one ();
   ctu_edge_if chan_two ();

   function automatic ctu_pkg::ctu_chan_cfg_t ctu_cfg(input logic [7:0] low, input logic second);
      ctu_pkg::ctu_chan_cfg_t c;
      c = second ? {low[`CTU_LOW_SEL2_HI:`CTU_LOW_SEL2_LO], low[`CTU_LOW_POL2]}
                 : {low[`CTU_LOW_SEL1_HI:`CTU_LOW_SEL1_LO], low[`CTU_LOW_POL1]};
      return c;
   endfunction

   assign chan_one.cfg = ctu_cfg(state.low, 1'b0);
   assign chan_two.cfg = ctu_cfg(state.low, 1'b1);

   // Only the second synchroniser stage reaches the selectors. [RQ21]
   ctu_edge_select u_sel_one (
      .i_pin_one     (state.pin_sync[0]),
      .i_pin_two     (state.pin_sync[1]),
      .i_capture_one (i_capture_unit_one),
      .i_capture_two (i_capture_unit_two),
      .chan          (chan_one)
   );

   ctu_edge_select u_sel_two (
      .i_pin_one     (state.pin_sync[0]),
      .i_pin_two     (state.pin_sync[1]),
      .i_capture_one (i_capture_unit_one),
      .i_capture_two (i_capture_unit_two),
      .chan          (chan_two)
   );

   logic       running;
   logic       gate_open;
   logic       hit_one;
   logic       hit_two;
   logic       wr_high;
   logic       wr_low;
   logic [7:0] low_written;
   logic       flag_one;
   logic       flag_two;
   logic       both_now;

   always_comb begin
      next_state = state;
      next_state.pin_meta = {i_ext_edge_pin_two, i_ext_edge_pin_one};
      next_state.pin_sync = state.pin_meta; // [RQ21]
      // Idle stop freezes the edge logic but leaves the registers reachable. [RQ1] [RQ2]
      running   = state.high[`CTU_HIGH_ENABLE] &&
                  !(state.high[`CTU_HIGH_IDLE_STOP] && i_idle_mode);
      gate_open = running && state.high[`CTU_HIGH_EDGE_GATE]; // [RQ4]
      wr_high   = 1'b0;
      wr_low    = 1'b0;
      next_state.err = 1'b0;
      case (state.bus)
         ctu_pkg::CTU_BUS_IDLE: begin
            if (i_avs_read || i_avs_write) begin
               next_state.bus = ctu_pkg::CTU_BUS_ANSWER;
               next_state.rdata = 32'h0000_0000;
               case (i_avs_address)
                  `CTU_ADDR_CTRL_HIGH: begin
                     next_state.rdata[7:0] = state.high & `CTU_HIGH_WRITE_MASK; // [RQ8]
                  end
                  `CTU_ADDR_CTRL_LOW: begin
                     next_state.rdata[7:0] = state.low; // [RQ13] [RQ14]
                  end
                  `CTU_ADDR_STATUS: begin
                     next_state.rdata[2:0] = {state.int_flag, state.current, state.trig};
                  end
                  default: begin
                     next_state.err = 1'b1;
                  end
               endcase
            end
         end
         ctu_pkg::CTU_BUS_ANSWER: begin
            next_state.bus = ctu_pkg::CTU_BUS_IDLE;
            next_state.err = state.err;
            // Writes land at the edge where the master sees waitrequest low, never earlier.
            wr_high = i_avs_write && i_avs_byteenable[0] &&
                      (i_avs_address == `CTU_ADDR_CTRL_HIGH);
            wr_low  = i_avs_write && i_avs_byteenable[0] &&
                      (i_avs_address == `CTU_ADDR_CTRL_LOW);
         end
         default: begin
            next_state.bus = ctu_pkg::CTU_BUS_IDLE;
         end
      endcase
      if (wr_high) begin
         next_state.high = i_avs_writedata[7:0] & `CTU_HIGH_WRITE_MASK; // [RQ8]
      end
      // Software may set or clear flags directly to drive the source by hand. [RQ13] [RQ14]
      low_written = wr_low ? i_avs_writedata[7:0] : state.low;
      hit_one  = gate_open && chan_one.hit; // [RQ17] [RQ18]
      // The set wins over a clear written in the same cycle. [RQ5]
      hit_two  = gate_open && chan_two.hit &&
                 (!state.high[`CTU_HIGH_EDGE_ORDER] || state.low[`CTU_LOW_FLAG1]);
      flag_one = low_written[`CTU_LOW_FLAG1] || hit_one;
      flag_two = low_written[`CTU_LOW_FLAG2] || hit_two;
      next_state.low = {low_written[7:2], flag_two, flag_one};
      next_state.current = state.high[`CTU_HIGH_ENABLE] && (flag_one ^ flag_two); // [RQ19]
      // The flag is a level that stays until the next bus write to the status word.
      next_state.int_flag = (state.current && !next_state.current) ? 1'b1 : // [RQ20]
                            ((i_avs_write && state.bus == ctu_pkg::CTU_BUS_ANSWER &&
                              i_avs_address == `CTU_ADDR_STATUS) ? 1'b0 : state.int_flag);
      both_now = flag_one && flag_two;
      next_state.trig = state.high[`CTU_HIGH_TRIG_EN] && both_now && // [RQ7] [RQ16] [RQ22]
                        !(state.low[`CTU_LOW_FLAG1] && state.low[`CTU_LOW_FLAG2]);
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         state <= '0; // [RQ1]
      end else begin
         state <= next_state;
      end
   end

   assign o_avs_waitrequest  = (state.bus != ctu_pkg::CTU_BUS_ANSWER);
   assign o_avs_readdata     = state.rdata;
   assign o_avs_response_err = state.err;
   assign o_unit_enable      = state.high[`CTU_HIGH_ENABLE];
   assign o_delay_gen_enable = state.high[`CTU_HIGH_DELAY_GEN]; // [RQ3]
   // Grounding overrides charging so a discharge never fights the source. [RQ6]
   assign o_source_ground    = state.high[`CTU_HIGH_GROUND];
   assign o_current_enable   = state.current && !state.high[`CTU_HIGH_GROUND];
   assign o_conv_trigger     = state.trig;
   assign o_unit_int_flag    = state.int_flag;

   a_order_second_flag: assert property (@(posedge i_clock) disable iff (i_reset) // [RQ5]
      ($past(state.high[`CTU_HIGH_EDGE_ORDER]) && !$past(state.low[`CTU_LOW_FLAG1]) &&
       !$past(state.low[`CTU_LOW_FLAG2]) && !$past(wr_low))
      |-> !state.low[`CTU_LOW_FLAG2])
      else $error("Second flag set before first under ordering.");

   a_gate_blocks_edges: assert property (@(posedge i_clock) disable iff (i_reset) // [RQ4]
      (!gate_open && !wr_low) |=> ($stable(state.low[1:0]) || $past(state.low[1:0]) != 2'h0
                                   && state.low[1:0] == $past(state.low[1:0])))
      else $error("Edge flag set while edges blocked.");

   a_hit_sets_flag: assert property (@(posedge i_clock) disable iff (i_reset) // [RQ17]
      hit_one |=> state.low[`CTU_LOW_FLAG1])
      else $error("Detected event did not set first flag.");

   a_current_one_flag: assert property (@(posedge i_clock) disable iff (i_reset) // [RQ19]
      o_current_enable |-> (state.low[0] ^ state.low[1]) && !o_source_ground)
      else $error("Current on without exactly one flag.");

   a_int_on_fall: assert property (@(posedge i_clock) disable iff (i_reset) // [RQ20]
      $fell(state.current) |-> state.int_flag)
      else $error("Interrupt flag missing after current off.");

   sequence s_both_rise;
      !(state.low[0] && state.low[1]) ##1 (state.low[0] && state.low[1]);
   endsequence

   a_trigger_pulse: assert property (@(posedge i_clock) disable iff (i_reset) // [RQ22]
      (s_both_rise ##0 $past(state.high[`CTU_HIGH_TRIG_EN]))
      |-> o_conv_trigger ##1 !o_conv_trigger)
      else $error("Conversion trigger not one cycle wide.");

   a_trigger_disabled: assert property (@(posedge i_clock) disable iff (i_reset) // [RQ7]
      o_conv_trigger |-> $past(state.high[`CTU_HIGH_TRIG_EN]))
      else $error("Trigger fired while disabled.");

   a_unused_bit_zero: assert property (@(posedge i_clock) disable iff (i_reset) // [RQ8]
      !state.high[`CTU_HIGH_UNUSED])
      else $error("Unimplemented control bit held a one.");

   a_bus_one_wait: assert property (@(posedge i_clock) disable iff (i_reset)
      (i_avs_read && o_avs_waitrequest) |=> !o_avs_waitrequest)
      else $error("Read not answered in one cycle.");

   a_idle_stop_freeze: assert property (@(posedge i_clock) disable iff (i_reset) // [RQ2]
      (state.high[`CTU_HIGH_IDLE_STOP] && i_idle_mode) |-> !gate_open)
      else $error("Edges passed while stopped in idle.");

   a_write_lands_answer: assert property (@(posedge i_clock) disable iff (i_reset) // [RQ8]
      (i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0] &&
       i_avs_address == `CTU_ADDR_CTRL_HIGH)
      |=> state.high == ($past(i_avs_writedata[7:0]) & `CTU_HIGH_WRITE_MASK))
      else $error("Control write did not land at the answer edge.");

   a_disabled_current_off: assert property (@(posedge i_clock) disable iff (i_reset) // [RQ1]
      !state.high[`CTU_HIGH_ENABLE] |=> !state.current)
      else $error("Current source on while unit disabled.");

   a_sync_two_stage: assert property (@(posedge i_clock) disable iff (i_reset) // [RQ21]
      state.pin_sync == $past(state.pin_meta))
      else $error("Edge pin skipped a synchroniser stage.");

   a_flag_set_wins: assert property (@(posedge i_clock) disable iff (i_reset) // [RQ17]
      (hit_one && wr_low && !i_avs_writedata[`CTU_LOW_FLAG1]) |=> state.low[`CTU_LOW_FLAG1])
      else $error("Software clear beat a detected event.");
endmodule

/* pkg/ctu_defs.svh */
// Register offsets, field positions, reset values and source encodings of the measurement unit.
`ifndef CTU_DEFS_SVH
`define CTU_DEFS_SVH
`define CTU_ADDR_CTRL_HIGH   4'h0
`define CTU_ADDR_CTRL_LOW    4'h4
`define CTU_ADDR_STATUS      4'h8
`define CTU_HIGH_ENABLE      7
`define CTU_HIGH_UNUSED      6
`define CTU_HIGH_IDLE_STOP   5
`define CTU_HIGH_DELAY_GEN   4
`define CTU_HIGH_EDGE_GATE   3
`define CTU_HIGH_EDGE_ORDER  2
`define CTU_HIGH_GROUND      1
`define CTU_HIGH_TRIG_EN     0
`define CTU_LOW_POL2         7
`define CTU_LOW_SEL2_HI      6
`define CTU_LOW_SEL2_LO      5
`define CTU_LOW_POL1         4
`define CTU_LOW_SEL1_HI      3
`define CTU_LOW_SEL1_LO      2
`define CTU_LOW_FLAG2        1
`define CTU_LOW_FLAG1        0
`define CTU_HIGH_WRITE_MASK  8'hBF
`define CTU_RESET_HIGH       8'h00
`define CTU_RESET_LOW        8'h00
`define CTU_SRC_PIN_ONE      2'h3
`define CTU_SRC_PIN_TWO      2'h2
`define CTU_SRC_CAPTURE_ONE  2'h1
`define CTU_SRC_CAPTURE_TWO  2'h0
`endif

/* pkg/ctu_pkg.sv */
// Types shared by the measurement unit modules.
package ctu_pkg;
   typedef enum logic [1:0] {
      CTU_BUS_IDLE,
      CTU_BUS_ANSWER
   } ctu_bus_state_t;

   typedef struct packed {
      logic [1:0] src;
      logic       pol;
   } ctu_chan_cfg_t;
endpackage

/* pkg/ctu_edge_if.sv */
// Interface carrying one edge channel's configuration and polarity-match result.
`timescale 1ns/1ns
interface ctu_edge_if;
   ctu_pkg::ctu_chan_cfg_t cfg;
   logic                   hit;
   modport selector (input cfg, output hit);
   modport owner    (output cfg, input hit);
endinterface

/* hdl/ctu_edge_select.sv */
// Source multiplexer and polarity match of one level-sensitive edge channel.
`timescale 1ns/1ns
`include "ctu_defs.svh"
module ctu_edge_select (
   input  wire logic       i_pin_one,
   input  wire logic       i_pin_two,
   input  wire logic       i_capture_one,
   input  wire logic       i_capture_two,
   ctu_edge_if.selector    chan
);
   logic level;

   always_comb begin
      case (chan.cfg.src) // [RQ11] [RQ12] [RQ15]
         `CTU_SRC_PIN_ONE:     level = i_pin_one;
         `CTU_SRC_PIN_TWO:     level = i_pin_two;
         `CTU_SRC_CAPTURE_ONE: level = i_capture_one;
         default:              level = i_capture_two;
      endcase
   end

   // A level, not a transition, counts as an event. [RQ9] [RQ10]
   assign chan.hit = (level == chan.cfg.pol);
endmodule

/* tb/ctu_edge_source.sv */
// Model of the four level sources that feed the edge channels.
`timescale 1ns/1ns
module ctu_edge_source (
   input  wire logic       i_clock,
   input  wire logic [3:0] i_levels,
   output logic            o_pin_one,
   output logic            o_pin_two,
   output logic            o_capture_one,
   output logic            o_capture_two
);
   // Levels change only at a clock edge and then hold, as real event sources do.
   always_ff @(posedge i_clock) begin
      {o_pin_one, o_pin_two, o_capture_one, o_capture_two} <= i_levels;
   end
endmodule

/* tb/charge_time_edge_control_bench.sv */
// Self-checking bench of the measurement unit edge and control logic.
`timescale 1ns/1ns
module charge_time_edge_control_bench;
   logic        i_clock, i_reset, rd, wr, idle, waitreq, err, e;
   logic        pin1, pin2, cap1, cap2, en, dgen, cur, gnd, trig, intf;
   logic [3:0]  addr, lv;
   logic [31:0] wdata, rdata, q, seed;
   logic [7:0]  h, l;
   logic [1:0]  f;
   int          bad_count, checks, trig_count, t0;
   ctu_top uut (.i_clock(i_clock), .i_reset(i_reset), .i_avs_address(addr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'h1),
      .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .o_avs_response_err(err),
      .i_idle_mode(idle), .i_ext_edge_pin_one(pin1), .i_ext_edge_pin_two(pin2),
      .i_capture_unit_one(cap1), .i_capture_unit_two(cap2), .o_unit_enable(en),
      .o_delay_gen_enable(dgen), .o_current_enable(cur), .o_source_ground(gnd),
      .o_conv_trigger(trig), .o_unit_int_flag(intf));
   ctu_edge_source src_model (.i_clock(i_clock), .i_levels(lv), .o_pin_one(pin1),
      .o_pin_two(pin2), .o_capture_one(cap1), .o_capture_two(cap2));
   initial begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end
   always @(posedge i_clock) if (trig === 1'b1) trig_count++;
   function logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // Flags after settling: sticky, set by a level match while the unit is active.
   function logic [1:0] mflags(input logic [7:0] hh, ll, input logic [3:0] s, input logic id);
      logic act, g1;
      act = hh[7] & hh[3] & !(hh[5] & id);
      g1 = ll[0] | (act & (s[ll[3:2]] == ll[4]));
      return {ll[1] | (act & (s[ll[6:5]] == ll[7]) & (!hh[2] | g1)), g1};
   endfunction
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // The request holds until waitrequest is seen low at a rising edge.
   task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clock);
      rd    <= !w;
      wr    <= w;
      addr  <= a;
      wdata <= {24'h0, d};
      @(posedge i_clock);
      while (waitreq !== 1'b0) @(posedge i_clock);
      q  = rdata;
      e  = err;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // A write lands at the answer edge, so one more edge passes before outputs are read.
   task wr_h(input logic [7:0] d);
      h = d & 8'hBF;
      bus(1'b1, 4'h0, d);
      @(posedge i_clock);
   endtask
   task cmp;
      repeat (6) @(posedge i_clock);
      f = mflags(h, {l[7:2], f}, lv, idle);
      bus(1'b0, 4'h4, 8'h00);
      chk("low", q, {24'h0, l[7:2], f});
      chk("current", {31'h0, cur}, {31'h0, (f[0] ^ f[1]) & !h[1] & h[7]});
   endtask
   task wr_l(input logic [7:0] d);
      l = d;
      f = d[1:0];
      bus(1'b1, 4'h4, d);
      cmp;
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #400000;
      bad_count++;
      tally_and_finish;
   end
   initial begin
      {i_reset, rd, wr, idle, addr, lv, wdata, h, l, f} = '0;
      i_reset = 1'b1;
      bad_count = 0;
      checks = 0;
      trig_count = 0;
      seed = 32'h6d0ce051;
      repeat (5) @(posedge i_clock);
      i_reset <= 1'b0;
      bus(1'b0, 4'h0, 8'h00);
      chk("high reset", q, 32'h0);
      cmp;
      chk("outputs reset", {27'h0, en, dgen, gnd, trig, intf}, 32'h0);
      wr_h(8'hFF);
      bus(1'b0, 4'h0, 8'h00);
      chk("high unused", q, 32'hBF);
      chk("ctrl outs", {29'h0, en, dgen, gnd}, 32'h7);
      bus(1'b0, 4'hC, 8'h00);
      chk("unmapped", {q[30:0], e}, 32'h1);
      wr_h(8'h88);
      chk("ctrl outs", {29'h0, en, dgen, gnd}, 32'h4);
      t0 = trig_count;
      // Flags are cleared with the gate shut, since a live match wins over the clear.
      for (int i = 0; i < 64; i++) begin
         seed = xs(seed);
         wr_h(8'h80);
         lv <= seed[3:0];
         idle <= seed[4];
         wr_l({i[5:0], 2'b00});
         wr_h(8'h88);
         cmp;
         wr_l({seed[10:5], f});
      end
      chk("no trigger", trig_count - t0, 0);
      lv <= 4'h0;
      wr_h(8'h80);
      wr_l(8'h00);
      wr_h(8'hA8);
      idle <= 1'b1;
      wr_l(8'h00);
      idle <= 1'b0;
      cmp;
      wr_h(8'h08);
      wr_l(8'h00);
      wr_h(8'h8D);
      lv <= 4'h1;
      wr_l(8'h94);
      t0 = trig_count;
      lv <= 4'h3;
      cmp;
      chk("trigger", trig_count - t0, 1);
      bus(1'b1, 4'h8, 8'h00);
      lv <= 4'h2;
      wr_l(8'h94);
      wr_h(8'h8F);
      cmp;
      wr_h(8'h8D);
      cmp;
      t0 = trig_count;
      lv <= 4'h3;
      cmp;
      chk("trigger", trig_count - t0, 1);
      bus(1'b0, 4'h8, 8'h00);
      chk("status", {30'h0, q[2:1]}, 32'h2);
      chk("int flag", {31'h0, intf}, 32'h1);
      bus(1'b1, 4'h8, 8'h00);
      @(posedge i_clock);
      chk("int clear", {31'h0, intf}, 32'h0);
      tally_and_finish;
   end
endmodule
